// file: core/addr_capture.sv
// Most recent RAM address capture
`timescale 1ns/1ps
module addr_capture (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  dma_events_if.capture ev
);
  import dma_status_pkg::*;

  logic [RAM_ADDR_W-1:0] last_addr_d;
  logic [RAM_ADDR_W-1:0] last_addr_q;

  assign last_addr_d = ev.ram_access ? ev.ram_addr : last_addr_q;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      last_addr_q <= RAM_ADDR_RESET;
    end else begin
      last_addr_q <= last_addr_d;
    end
  end

  assign ev.last_addr = last_addr_q;

  addr_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    !ev.ram_access |=> $stable(last_addr_q))
    else $error("Captured RAM address changed without an access");

endmodule : addr_capture

// file: core/chan_tracker.sv
// Last active channel tracker
`timescale 1ns/1ps
module chan_tracker (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  dma_events_if.tracker ev
);
  import dma_status_pkg::*;

  logic hit;
  logic [CH_CODE_W-1:0] code;
  logic [CH_CODE_W-1:0] last_ch_d;
  logic [CH_CODE_W-1:0] last_ch_q;

  // Highest channel wins if two complete together; only 0..7 can result
  always_comb begin
    hit = 1'b0;
    code = NO_XFER_CODE;
    for (int i = 0; i < CH_NUM; i++) begin
      if (ev.xfer_done[i]) begin
        hit = 1'b1;
        code = CH_CODE_W'(i);
      end
    end
  end

  assign last_ch_d = hit ? code : last_ch_q;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      last_ch_q <= NO_XFER_CODE;
    end else begin
      last_ch_q <= last_ch_d;
    end
  end

  assign ev.last_ch = last_ch_q;

  code_range_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (last_ch_q <= LAST_VALID_CODE) || (last_ch_q == NO_XFER_CODE))
    else $error("Last channel field holds a reserved code");

endmodule : chan_tracker

// file: core/dma_events_if.sv
// Transfer events and captured results passed between the status submodules
`timescale 1ns/1ps
interface dma_events_if;
  import dma_status_pkg::*;

  logic [CH_NUM-1:0] xfer_done;
  logic ram_access;
  logic [RAM_ADDR_W-1:0] ram_addr;
  logic [CH_CODE_W-1:0] last_ch;
  logic [RAM_ADDR_W-1:0] last_addr;

  modport source (
    output xfer_done, ram_access, ram_addr,
    input last_ch, last_addr
  );
  modport tracker (
    input xfer_done,
    output last_ch
  );
  modport capture (
    input ram_access, ram_addr,
    output last_addr
  );
endinterface : dma_events_if

// file: core/dma_status_pkg.sv
// Constants shared by the DMA status reporting block
package dma_status_pkg;

  localparam int CH_NUM = 8;
  localparam int CH_CODE_W = 4;
  localparam int DATA_W = 16;
  localparam int RAM_ADDR_W = 16;
  localparam int REG_ADDR_W = 4;

  // Register addresses on the plain register port
  localparam logic [REG_ADDR_W-1:0] STATUS_ONE_ADDR = 4'h0;
  localparam logic [REG_ADDR_W-1:0] LAST_RAM_ADDR_ADDR = 4'h1;

  // Field layout of the controller status register
  localparam int RSVD_MSB = 15;
  localparam int RSVD_LSB = 12;
  localparam int RSVD_W = RSVD_MSB - RSVD_LSB + 1;
  localparam int LAST_CH_MSB = 11;
  localparam int LAST_CH_LSB = 8;
  localparam int PP_MSB = 7;
  localparam int PP_LSB = 0;

  // Reset, idle and range-limit values
  localparam logic [CH_CODE_W-1:0] NO_XFER_CODE = 4'hF;
  localparam logic [CH_CODE_W-1:0] LAST_VALID_CODE = 4'h7;
  localparam logic [RSVD_W-1:0] RSVD_VALUE = 4'h0;
  localparam logic [CH_NUM-1:0] PP_RESET = 8'h00;
  localparam logic [RAM_ADDR_W-1:0] RAM_ADDR_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] READ_IDLE = 16'h0000;

endpackage : dma_status_pkg

// file: core/dma_status_report.sv
// DMA controller status reporting: last channel, ping-pong flags, last RAM address
`timescale 1ns/1ps
module dma_status_report (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [dma_status_pkg::REG_ADDR_W-1:0] reg_addr_in,
  input wire logic [dma_status_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [dma_status_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic [dma_status_pkg::CH_NUM-1:0] xfer_done_in,
  input wire logic [dma_status_pkg::CH_NUM-1:0] pingpong_sel_in,
  input wire logic ram_access_in,
  input wire logic [dma_status_pkg::RAM_ADDR_W-1:0] ram_addr_in,
  output logic [dma_status_pkg::CH_CODE_W-1:0] last_active_channel_field_out,
  output logic [dma_status_pkg::RAM_ADDR_W-1:0] dma_last_ram_address_out
);
  import dma_status_pkg::*;

  dma_events_if ev ();

  logic [CH_NUM-1:0] pingpong_select_flag_q;
  logic [DATA_W-1:0] dma_controller_status_one;
  logic [DATA_W-1:0] dma_last_ram_address;
  logic sel_status_one;
  logic sel_last_addr;
  logic [DATA_W-1:0] read_mux;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] rdata_q;
  logic seen_xfer_q;

  // Events go to the submodules as they arrive; all are on this clock
  assign ev.xfer_done = xfer_done_in;
  assign ev.ram_access = ram_access_in;
  assign ev.ram_addr = ram_addr_in;

  chan_tracker u_chan_tracker (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .ev(ev.tracker)
  );

  addr_capture u_addr_capture (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .ev(ev.capture)
  );

  // Ping-pong flags follow the buffer select of each channel
  generate
    for (genvar g = 0; g < CH_NUM; g++) begin : g_pp
      always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          pingpong_select_flag_q[g] <= PP_RESET[g];
        end else begin
          pingpong_select_flag_q[g] <= pingpong_sel_in[g];
        end
      end
    end
  endgenerate

  // Register images; upper nibble tied so no write can reach it
  assign dma_controller_status_one = {RSVD_VALUE, ev.last_ch, pingpong_select_flag_q};
  assign dma_last_ram_address = ev.last_addr;

  // Address decode
  assign sel_status_one = (reg_addr_in == STATUS_ONE_ADDR);
  assign sel_last_addr = (reg_addr_in == LAST_RAM_ADDR_ADDR);

  // Unmapped addresses read zero
  assign read_mux = sel_status_one ? dma_controller_status_one :
                    sel_last_addr ? dma_last_ram_address : READ_IDLE;

  // Read data stands for exactly the cycle after the strobe
  assign rdata_d = reg_rd_in ? read_mux : READ_IDLE;

  // Writes are decoded nowhere: both registers are read-only by construction
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_q <= READ_IDLE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign last_active_channel_field_out = ev.last_ch;
  assign dma_last_ram_address_out = ev.last_addr;

  // Helper for the checks only: has any channel transferred since reset
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      seen_xfer_q <= 1'b0;
    end else if (|xfer_done_in) begin
      seen_xfer_q <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence rd_status_s;
    reg_rd_in && (reg_addr_in == STATUS_ONE_ADDR);
  endsequence

  sequence rd_addr_s;
    reg_rd_in && (reg_addr_in == LAST_RAM_ADDR_ADDR);
  endsequence

  sequence single_done_s;
    $onehot(xfer_done_in);
  endsequence

  sequence quiet_write_s;
    reg_wr_in && !ram_access_in && (xfer_done_in == '0);
  endsequence

  no_xfer_code_a: assert property (
    !seen_xfer_q |-> (ev.last_ch == NO_XFER_CODE))
    else $error("Last channel not 1111 before any transfer");

  idle_read_a: assert property (
    (!seen_xfer_q && !(|xfer_done_in)) ##0 rd_status_s
      |=> (reg_rdata_out[LAST_CH_MSB:LAST_CH_LSB] == NO_XFER_CODE))
    else $error("Status read shows a channel before any transfer");

  chan_load_a: assert property (
    single_done_s |=> ((CH_NUM'(1) << ev.last_ch) == $past(xfer_done_in)))
    else $error("Last channel does not match the completing channel");

  chan_read_a: assert property (
    single_done_s ##1 (xfer_done_in == '0) ##1 (rd_status_s and (xfer_done_in == '0))
      |=> ((CH_NUM'(1) << reg_rdata_out[LAST_CH_MSB:LAST_CH_LSB]) == $past(xfer_done_in, 3)))
    else $error("Status read does not show the completing channel");

  pp_read_a: assert property (
    rd_status_s |=> (reg_rdata_out[PP_MSB:PP_LSB] == $past(pingpong_sel_in, 2)))
    else $error("Ping-pong flags do not follow the buffer select");

  addr_cap_a: assert property (
    ram_access_in |=> (dma_last_ram_address_out == $past(ram_addr_in)))
    else $error("RAM address not captured on access");

  addr_read_a: assert property (
    ram_access_in ##1 !ram_access_in ##1 (rd_addr_s and !ram_access_in)
      |=> (reg_rdata_out == $past(ram_addr_in, 3)))
    else $error("Address register read does not return the last access");

  rsvd_zero_a: assert property (
    rd_status_s |=> (reg_rdata_out[RSVD_MSB:RSVD_LSB] == RSVD_VALUE))
    else $error("Reserved status bits read non-zero");

  write_void_a: assert property (
    quiet_write_s |=> ($stable(ev.last_ch) && $stable(ev.last_addr)))
    else $error("Software write changed a status value");

  read_window_a: assert property (
    !reg_rd_in |=> (reg_rdata_out == READ_IDLE))
    else $error("Read data present outside the answer cycle");

  sequence rd_other_s;
    reg_rd_in && !sel_status_one && !sel_last_addr;
  endsequence

  sequence no_done_s;
    xfer_done_in == '0;
  endsequence

  sequence soft_write_s;
    reg_wr_in && !reg_rd_in;
  endsequence

  // Whole-word checks of each read answer against the visible state
  status_word_a: assert property (
    rd_status_s |=> (reg_rdata_out == {RSVD_VALUE, $past(last_active_channel_field_out),
      $past(pingpong_select_flag_q)}))
    else $error("Status read word does not match the held state");

  addr_word_a: assert property (
    rd_addr_s |=> (reg_rdata_out == $past(dma_last_ram_address_out)))
    else $error("Address read word does not match the held address");

  // Unmapped reads must not leak either register image
  unmapped_read_a: assert property (
    rd_other_s |=> (reg_rdata_out == READ_IDLE))
    else $error("Unmapped read returned data");

  chan_hold_a: assert property (
    no_done_s |=> $stable(ev.last_ch))
    else $error("Last channel changed without a transfer");

  addr_write_a: assert property (
    soft_write_s ##0 !ram_access_in |=> $stable(dma_last_ram_address_out))
    else $error("Software write changed the captured address");

  pp_write_a: assert property (
    soft_write_s ##0 $stable(pingpong_sel_in) |=> $stable(pingpong_select_flag_q))
    else $error("Software write changed the ping-pong flags");

  // Per channel: highest completing channel is recorded, flags track the select
  generate
    for (genvar k = 0; k < CH_NUM; k++) begin : g_chk
      localparam logic [CH_CODE_W-1:0] CH_CODE = CH_CODE_W'(k);
      logic above_idle;

      // No higher channel completing in the same cycle
      assign above_idle = ((xfer_done_in >> (k + 1)) == '0);

      sequence top_done_s;
        xfer_done_in[k] && above_idle;
      endsequence

      chan_code_a: assert property (
        top_done_s |=> (ev.last_ch == CH_CODE))
        else $error("Last channel not set to the highest completing channel");

      pp_set_a: assert property (
        pingpong_sel_in[k] |=> pingpong_select_flag_q[k])
        else $error("Ping-pong flag not set for secondary select");

      pp_clear_a: assert property (
        !pingpong_sel_in[k] |=> !pingpong_select_flag_q[k])
        else $error("Ping-pong flag not clear for primary select");

      pp_bit_read_a: assert property (
        rd_status_s |=> (reg_rdata_out[PP_LSB + k] == $past(pingpong_select_flag_q[k])))
        else $error("Status read bit differs from its ping-pong flag");
    end
  endgenerate

endmodule : dma_status_report

// file: test/tb_dma_status_report.sv
// Self-checking testbench for the DMA status reporting block
`timescale 1ns/1ps
module tb_dma_status_report;
  import dma_status_pkg::*;

  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [REG_ADDR_W-1:0] reg_addr_in = 4'h0;
  logic [DATA_W-1:0] reg_wdata_in = 16'h0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [DATA_W-1:0] reg_rdata_out;
  logic [CH_NUM-1:0] xfer_done_in = 8'h00;
  logic [CH_NUM-1:0] pingpong_sel_in = 8'h00;
  logic ram_access_in = 1'b0;
  logic [RAM_ADDR_W-1:0] ram_addr_in = 16'h0000;
  logic [CH_CODE_W-1:0] last_active_channel_field_out;
  logic [RAM_ADDR_W-1:0] dma_last_ram_address_out;
  int err_count = 0;
  int total_checks = 0;

  dma_status_report i_dut (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .xfer_done_in(xfer_done_in),
    .pingpong_sel_in(pingpong_sel_in),
    .ram_access_in(ram_access_in),
    .ram_addr_in(ram_addr_in),
    .last_active_channel_field_out(last_active_channel_field_out),
    .dma_last_ram_address_out(dma_last_ram_address_out)
  );

  always #20 clk_sys_in = ~clk_sys_in;

  task automatic conclude();
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Read data stand only in the cycle after the strobe, so sample right there
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= v;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    reg_wdata_in <= ~v;
  endtask : wr

  task automatic xfer(input logic [7:0] v);
    @(posedge clk_sys_in);
    xfer_done_in <= v;
    @(posedge clk_sys_in);
    xfer_done_in <= 8'h00;
    #1;
  endtask : xfer

  // Watchdog: a hang counts as a mismatch
  initial begin
    #(100000 * 40);
    err_count++;
    conclude();
  end

  initial begin
    logic [15:0] d;
    logic [7:0] pp;
    logic [3:0] c;
    repeat (5) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    rd(STATUS_ONE_ADDR, d);
    chk(d, 16'h0F00);
    @(posedge clk_sys_in);
    #1 chk(reg_rdata_out, READ_IDLE);
    rd(LAST_RAM_ADDR_ADDR, d);
    chk(d, 16'h0000);
    rd(4'h9, d);
    chk(d, READ_IDLE);
    for (int ch = 0; ch < CH_NUM; ch++) begin
      c = ch[3:0];
      pp = (8'h01 << ch) ^ 8'h5A;
      @(posedge clk_sys_in);
      pingpong_sel_in <= pp;
      xfer(8'h01 << ch);
      chk({12'h000, last_active_channel_field_out}, {12'h000, c});
      rd(STATUS_ONE_ADDR, d);
      chk(d, {RSVD_VALUE, c, pp});
    end
    // Simultaneous completions record the highest channel
    xfer(8'h28);
    chk({12'h000, last_active_channel_field_out}, 16'h0005);
    // Back-to-back RAM accesses, then an address without its strobe
    @(posedge clk_sys_in);
    ram_access_in <= 1'b1;
    ram_addr_in <= 16'h1234;
    @(posedge clk_sys_in);
    ram_addr_in <= 16'hFFFF;
    #1 chk(dma_last_ram_address_out, 16'h1234);
    @(posedge clk_sys_in);
    ram_access_in <= 1'b0;
    ram_addr_in <= 16'h0000;
    #1 chk(dma_last_ram_address_out, 16'hFFFF);
    rd(LAST_RAM_ADDR_ADDR, d);
    chk(d, 16'hFFFF);
    // Writes must leave both registers untouched
    wr(STATUS_ONE_ADDR, 16'hFFFF);
    wr(LAST_RAM_ADDR_ADDR, 16'h0000);
    rd(STATUS_ONE_ADDR, d);
    chk(d, {RSVD_VALUE, 4'h5, pp});
    rd(LAST_RAM_ADDR_ADDR, d);
    chk(d, 16'hFFFF);
    // Second reset in mid-run
    @(posedge clk_sys_in);
    pingpong_sel_in <= 8'h00;
    rst_b_in <= 1'b0;
    #5 chk({12'h000, last_active_channel_field_out}, 16'h000F);
    chk(dma_last_ram_address_out, RAM_ADDR_RESET);
    repeat (5) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    rd(STATUS_ONE_ADDR, d);
    chk(d, 16'h0F00);
    conclude();
  end
endmodule : tb_dma_status_report
